// ---- design/oag_pkg.sv ----
package oag_pkg;

    // ****************************************
    // Addressing modes and sequencer states
    // ****************************************
    typedef enum logic [9:0] {
        MODE_IMPLIED = 10'h001,
        MODE_LITERAL = 10'h002,
        MODE_PAGE_ZERO = 10'h004,
        MODE_FULL_ADDRESS = 10'h008,
        MODE_POINTER = 10'h010,
        MODE_POINTER_BYTE = 10'h020,
        MODE_POINTER_WORD = 10'h040,
        MODE_PC_OFFSET = 10'h080,
        MODE_BIT_WRITE = 10'h100,
        MODE_BIT_JUMP = 10'h200
    } oag_mode_e;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_OPCODE = 5'h02,
        ST_BYTE1 = 5'h04,
        ST_BYTE2 = 5'h08,
        ST_TEST = 5'h10
    } oag_state_e;

    // ****************************************
    // Opcode upper nibble groups
    // ****************************************
    localparam logic [3:0] NIB_BIT_JUMP = 4'h0;
    localparam logic [3:0] NIB_BIT_WRITE = 4'h1;
    localparam logic [3:0] NIB_PC_OFFSET = 4'h2;
    localparam logic [3:0] NIB_RMW_PAGE = 4'h3;
    localparam logic [3:0] NIB_RMW_ACC = 4'h4;
    localparam logic [3:0] NIB_RMW_INDEX = 4'h5;
    localparam logic [3:0] NIB_RMW_PTR_BYTE = 4'h6;
    localparam logic [3:0] NIB_RMW_PTR = 4'h7;
    localparam logic [3:0] NIB_LITERAL = 4'ha;
    localparam logic [3:0] NIB_PAGE_ZERO = 4'hb;
    localparam logic [3:0] NIB_FULL_ADDRESS = 4'hc;
    localparam logic [3:0] NIB_PTR_WORD = 4'hd;
    localparam logic [3:0] NIB_PTR_BYTE = 4'he;
    localparam logic [3:0] NIB_PTR = 4'hf;

    // ****************************************
    // Instruction lengths and reset values
    // ****************************************
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;
    localparam logic [15:0] PC_STEP_ONE = 16'h0001;
    localparam logic [15:0] PC_STEP_TWO = 16'h0002;
    localparam logic [15:0] PC_STEP_THREE = 16'h0003;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage

// ---- design/oag_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
module oag_decode
(
    // Opcode in
    input wire logic [7:0] opcode,
    // Decoded mode and length
    output oag_pkg::oag_mode_e mode,
    output logic [1:0] instr_len
);

    always_comb
    begin
        case (opcode[7:4])
            oag_pkg::NIB_BIT_JUMP: mode = oag_pkg::MODE_BIT_JUMP;
            oag_pkg::NIB_BIT_WRITE: mode = oag_pkg::MODE_BIT_WRITE;
            oag_pkg::NIB_PC_OFFSET: mode = oag_pkg::MODE_PC_OFFSET;
            oag_pkg::NIB_RMW_PAGE: mode = oag_pkg::MODE_PAGE_ZERO;
            oag_pkg::NIB_RMW_ACC: mode = oag_pkg::MODE_IMPLIED;
            oag_pkg::NIB_RMW_INDEX: mode = oag_pkg::MODE_IMPLIED;
            oag_pkg::NIB_RMW_PTR_BYTE: mode = oag_pkg::MODE_POINTER_BYTE;
            oag_pkg::NIB_RMW_PTR: mode = oag_pkg::MODE_POINTER;
            oag_pkg::NIB_LITERAL: mode = oag_pkg::MODE_LITERAL;
            oag_pkg::NIB_PAGE_ZERO: mode = oag_pkg::MODE_PAGE_ZERO;
            oag_pkg::NIB_FULL_ADDRESS: mode = oag_pkg::MODE_FULL_ADDRESS;
            oag_pkg::NIB_PTR_WORD: mode = oag_pkg::MODE_POINTER_WORD;
            oag_pkg::NIB_PTR_BYTE: mode = oag_pkg::MODE_POINTER_BYTE;
            oag_pkg::NIB_PTR: mode = oag_pkg::MODE_POINTER;
            // Control group 8..9 has no operand
            default: mode = oag_pkg::MODE_IMPLIED;
        endcase
        case (mode)
            oag_pkg::MODE_IMPLIED,
            oag_pkg::MODE_POINTER: instr_len = oag_pkg::LEN_ONE;
            oag_pkg::MODE_FULL_ADDRESS,
            oag_pkg::MODE_POINTER_WORD,
            oag_pkg::MODE_BIT_JUMP: instr_len = oag_pkg::LEN_THREE;
            default: instr_len = oag_pkg::LEN_TWO;
        endcase
    end

endmodule
`default_nettype wire

// ---- design/oag_core.sv ----
// What this block does
// - Ten operand addressing modes are decoded and served, no more and no fewer.
// - An implied-mode instruction is one byte, fetches no operand bytes and advances the counter by one.
// - Literal mode places the operand one past the opcode and advances the counter by two.
// - Page-zero mode takes the next byte as low address with a zero high byte and advances by two.
// - Full-address mode takes the next byte as high address, the one after as low, and advances by three.
// - Pointer mode uses the pointer value as low address with a zero high byte and advances by one.
// - Pointer-plus-byte mode adds pointer and offset unsigned, the carry becoming the high byte, advance two.
// - Pointer-plus-word mode adds pointer to the low offset byte and its carry into the high byte, advance three.
// - A relative branch adds the signed offset to the counter plus two only when its condition holds.
// - A single-bit write takes the bit from the opcode, the page-zero address from the next byte, advance two.
// - Bit-test-with-jump tests a page-zero bit for the opcode polarity and jumps by the signed third byte.
// - Every bit-test-with-jump copies the tested bit into the carry flag, taken or not.
`timescale 1ns/10ps
`default_nettype none
module oag_core
#(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Instruction request
    input wire logic start,
    input wire logic [ADDR_W-1:0] pc_in,
    input wire logic [DATA_W-1:0] index_in,
    input wire logic branch_cond,
    // Memory read port, data taken in the same cycle as the strobe
    output logic [ADDR_W-1:0] mem_addr,
    output logic mem_rd,
    input wire logic [DATA_W-1:0] mem_rdata,
    // Results
    output logic busy,
    output logic done,
    output oag_pkg::oag_mode_e addr_mode,
    output logic [ADDR_W-1:0] operand_location,
    output logic operand_valid,
    output logic [ADDR_W-1:0] pc_next,
    // Carry flag update
    output logic carry_we,
    output logic carry_bit,
    // Single-bit write request
    output logic bit_write_en,
    output logic [2:0] bit_write_num,
    output logic bit_write_value
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [ADDR_W-1:0] pc_plus(input logic [ADDR_W-1:0] base, input logic [ADDR_W-1:0] step);
        pc_plus = base + step;
    endfunction

    // Signed 8-bit displacement added to an already advanced counter
    function automatic logic [ADDR_W-1:0] branch_add(input logic [ADDR_W-1:0] base, input logic [DATA_W-1:0] off);
        logic [ADDR_W-1:0] full_address_mode;
        full_address_mode = {{(ADDR_W-DATA_W){off[DATA_W-1]}}, off};
        branch_add = base + full_address_mode;
    endfunction

    function automatic logic [ADDR_W-1:0] page_zero(input logic [DATA_W-1:0] low);
        page_zero = {{(ADDR_W-DATA_W){1'b0}}, low};
    endfunction

    // ****************************************
    // State
    // ****************************************
    oag_pkg::oag_state_e state_reg, state_next;
    oag_pkg::oag_mode_e mode_reg, mode_next;
    oag_pkg::oag_mode_e dec_mode;
    logic [1:0] dec_len;
    logic [7:0] opcode_reg, opcode_next;
    logic [DATA_W-1:0] byte1_reg, byte1_next;
    logic [DATA_W-1:0] byte2_reg, byte2_next;
    logic [DATA_W-1:0] index_reg, index_next;
    logic [ADDR_W-1:0] pc_base_reg, pc_base_next;
    logic branch_cond_reg, branch_cond_next;
    logic [ADDR_W-1:0] mem_addr_next;
    logic mem_rd_next;
    logic busy_next;
    logic done_next;
    logic [ADDR_W-1:0] operand_location_next;
    logic operand_valid_next;
    logic [ADDR_W-1:0] pc_next_next;
    logic carry_we_next;
    logic carry_bit_next;
    logic bit_write_en_next;
    logic [2:0] bit_write_num_next;
    logic bit_write_value_next;
    logic [DATA_W:0] sum_low;
    logic tested_bit;

    // Decode straight off the read data in the opcode cycle
    oag_decode u_decode
    (
        .opcode(mem_rdata[7:0]),
        .mode(dec_mode),
        .instr_len(dec_len)
    );

    // ****************************************
    // Sequencer next state
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        mode_next = mode_reg;
        opcode_next = opcode_reg;
        byte1_next = byte1_reg;
        byte2_next = byte2_reg;
        index_next = index_reg;
        pc_base_next = pc_base_reg;
        branch_cond_next = branch_cond_reg;
        mem_addr_next = mem_addr;
        mem_rd_next = 1'b0;
        busy_next = busy;
        done_next = 1'b0;
        operand_location_next = operand_location;
        operand_valid_next = operand_valid;
        pc_next_next = pc_next;
        carry_we_next = 1'b0;
        carry_bit_next = carry_bit;
        bit_write_en_next = 1'b0;
        bit_write_num_next = bit_write_num;
        bit_write_value_next = bit_write_value;
        sum_low = '0;
        tested_bit = 1'b0;
        case (state_reg)
            oag_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    // Pointer and condition are captured once so a moving core cannot skew them
                    pc_base_next = pc_in;
                    index_next = index_in;
                    branch_cond_next = branch_cond;
                    mem_addr_next = pc_in;
                    mem_rd_next = 1'b1;
                    busy_next = 1'b1;
                    operand_valid_next = 1'b0;
                    state_next = oag_pkg::ST_OPCODE;
                end
            end
            oag_pkg::ST_OPCODE:
            begin
                opcode_next = mem_rdata[7:0];
                mode_next = dec_mode;
                if (dec_len == oag_pkg::LEN_ONE)
                begin
                    // No operand bytes fetched for one-byte forms
                    done_next = 1'b1;
                    busy_next = 1'b0;
                    pc_next_next = pc_plus(pc_base_reg, oag_pkg::PC_STEP_ONE);
                    if (dec_mode == oag_pkg::MODE_POINTER)
                    begin
                        operand_location_next = page_zero(index_reg);
                        operand_valid_next = 1'b1;
                    end
                    state_next = oag_pkg::ST_IDLE;
                end
                else
                begin
                    mem_addr_next = pc_plus(pc_base_reg, oag_pkg::PC_STEP_ONE);
                    mem_rd_next = 1'b1;
                    state_next = oag_pkg::ST_BYTE1;
                end
            end
            oag_pkg::ST_BYTE1:
            begin
                byte1_next = mem_rdata;
                state_next = oag_pkg::ST_IDLE;
                done_next = 1'b1;
                busy_next = 1'b0;
                pc_next_next = pc_plus(pc_base_reg, oag_pkg::PC_STEP_TWO);
                operand_valid_next = 1'b1;
                case (mode_reg)
                    oag_pkg::MODE_LITERAL:
                        operand_location_next = pc_plus(pc_base_reg, oag_pkg::PC_STEP_ONE);
                    oag_pkg::MODE_PAGE_ZERO:
                        operand_location_next = page_zero(mem_rdata);
                    oag_pkg::MODE_BIT_WRITE:
                    begin
                        operand_location_next = page_zero(mem_rdata);
                        bit_write_en_next = 1'b1;
                        bit_write_num_next = opcode_reg[3:1];
                        bit_write_value_next = ~opcode_reg[0];
                    end
                    oag_pkg::MODE_POINTER_BYTE:
                    begin
                        sum_low = {1'b0, index_reg} + {1'b0, mem_rdata};
                        operand_location_next = {{(ADDR_W-DATA_W-1){1'b0}}, sum_low};
                    end
                    oag_pkg::MODE_PC_OFFSET:
                    begin
                        operand_valid_next = 1'b0;
                        if (branch_cond_reg)
                            pc_next_next = branch_add(pc_plus(pc_base_reg, oag_pkg::PC_STEP_TWO), mem_rdata);
                    end
                    default:
                    begin
                        // Three-byte forms need the next byte
                        done_next = 1'b0;
                        busy_next = 1'b1;
                        operand_valid_next = 1'b0;
                        pc_next_next = pc_next;
                        mem_addr_next = pc_plus(pc_base_reg, oag_pkg::PC_STEP_TWO);
                        mem_rd_next = 1'b1;
                        state_next = oag_pkg::ST_BYTE2;
                    end
                endcase
            end
            oag_pkg::ST_BYTE2:
            begin
                byte2_next = mem_rdata;
                pc_next_next = pc_plus(pc_base_reg, oag_pkg::PC_STEP_THREE);
                case (mode_reg)
                    oag_pkg::MODE_FULL_ADDRESS:
                    begin
                        operand_location_next = {byte1_reg, mem_rdata};
                        operand_valid_next = 1'b1;
                        done_next = 1'b1;
                        busy_next = 1'b0;
                        state_next = oag_pkg::ST_IDLE;
                    end
                    oag_pkg::MODE_POINTER_WORD:
                    begin
                        sum_low = {1'b0, index_reg} + {1'b0, mem_rdata};
                        operand_location_next = {byte1_reg + {{(DATA_W-1){1'b0}}, sum_low[DATA_W]},
                                                 sum_low[DATA_W-1:0]};
                        operand_valid_next = 1'b1;
                        done_next = 1'b1;
                        busy_next = 1'b0;
                        state_next = oag_pkg::ST_IDLE;
                    end
                    default:
                    begin
                        // Bit test: read the page-zero byte before deciding
                        pc_next_next = pc_next;
                        operand_location_next = page_zero(byte1_reg);
                        mem_addr_next = page_zero(byte1_reg);
                        mem_rd_next = 1'b1;
                        state_next = oag_pkg::ST_TEST;
                    end
                endcase
            end
            oag_pkg::ST_TEST:
            begin
                tested_bit = mem_rdata[opcode_reg[3:1]];
                carry_we_next = 1'b1;
                carry_bit_next = tested_bit;
                operand_valid_next = 1'b1;
                // Even opcodes jump on a one, odd on a zero
                if (tested_bit ^ opcode_reg[0])
                    pc_next_next = branch_add(pc_plus(pc_base_reg, oag_pkg::PC_STEP_THREE), byte2_reg);
                else
                    pc_next_next = pc_plus(pc_base_reg, oag_pkg::PC_STEP_THREE);
                done_next = 1'b1;
                busy_next = 1'b0;
                state_next = oag_pkg::ST_IDLE;
            end
            default:
            begin
                state_next = oag_pkg::ST_IDLE;
                busy_next = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= oag_pkg::ST_IDLE;
            mode_reg <= oag_pkg::MODE_IMPLIED;
            opcode_reg <= oag_pkg::BYTE_RESET;
            byte1_reg <= oag_pkg::BYTE_RESET;
            byte2_reg <= oag_pkg::BYTE_RESET;
            index_reg <= oag_pkg::BYTE_RESET;
            pc_base_reg <= oag_pkg::ADDR_RESET;
            branch_cond_reg <= 1'b0;
            mem_addr <= oag_pkg::ADDR_RESET;
            mem_rd <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            operand_location <= oag_pkg::ADDR_RESET;
            operand_valid <= 1'b0;
            pc_next <= oag_pkg::ADDR_RESET;
            carry_we <= 1'b0;
            carry_bit <= 1'b0;
            bit_write_en <= 1'b0;
            bit_write_num <= 3'h0;
            bit_write_value <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            opcode_reg <= opcode_next;
            byte1_reg <= byte1_next;
            byte2_reg <= byte2_next;
            index_reg <= index_next;
            pc_base_reg <= pc_base_next;
            branch_cond_reg <= branch_cond_next;
            mem_addr <= mem_addr_next;
            mem_rd <= mem_rd_next;
            busy <= busy_next;
            done <= done_next;
            operand_location <= operand_location_next;
            operand_valid <= operand_valid_next;
            pc_next <= pc_next_next;
            carry_we <= carry_we_next;
            carry_bit <= carry_bit_next;
            bit_write_en <= bit_write_en_next;
            bit_write_num <= bit_write_num_next;
            bit_write_value <= bit_write_value_next;
        end
    end

    assign addr_mode = mode_reg;

endmodule
`default_nettype wire

// ---- tb/oag_core_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module oag_core_monitor
#(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
)
(
    // Clock and requests
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [ADDR_W-1:0] pc_in,
    input wire logic [DATA_W-1:0] index_in,
    input wire logic branch_cond,
    // Memory port
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_rd,
    // Results
    input wire logic busy,
    input wire logic done,
    input var oag_pkg::oag_mode_e addr_mode,
    input wire logic [ADDR_W-1:0] operand_location,
    input wire logic operand_valid,
    input wire logic [ADDR_W-1:0] pc_next,
    input wire logic carry_we,
    input wire logic carry_bit,
    input wire logic bit_write_en
);
    // ************
    // Request capture
    // ************
    logic take;
    logic cond_reg;
    logic [ADDR_W-1:0] pc_reg;
    logic [DATA_W-1:0] idx_reg;
    assign take = start && !busy;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pc_reg <= '0;
            idx_reg <= '0;
            cond_reg <= 1'b0;
        end
        else if (take)
        begin
            pc_reg <= pc_in;
            idx_reg <= index_in;
            cond_reg <= branch_cond;
        end
    end
    // ************
    // Checks
    // ************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    fetch_opcode_a: assert property (take |=> busy && mem_rd && mem_addr == $past(pc_in))
        else $error("opcode fetch not at request address");
    done_bound_a: assert property (take |-> ##[1:6] done)
        else $error("no done after request");
    implied_len_a: assert property (done && addr_mode == oag_pkg::MODE_IMPLIED |->
        pc_next == pc_reg + 16'h0001 && !operand_valid) else $error("implied result wrong");
    literal_loc_a: assert property (done && addr_mode == oag_pkg::MODE_LITERAL |->
        operand_location == pc_reg + 16'h0001 && pc_next == pc_reg + 16'h0002) else $error("literal result wrong");
    page_zero_a: assert property (done && (addr_mode == oag_pkg::MODE_PAGE_ZERO ||
        addr_mode == oag_pkg::MODE_BIT_WRITE) |-> operand_location[15:8] == 8'h00 && pc_next == pc_reg + 16'h0002)
        else $error("page zero result wrong");
    three_byte_a: assert property (done && (addr_mode == oag_pkg::MODE_FULL_ADDRESS ||
        addr_mode == oag_pkg::MODE_POINTER_WORD) |-> pc_next == pc_reg + 16'h0003) else $error("three byte step wrong");
    pointer_loc_a: assert property (done && addr_mode == oag_pkg::MODE_POINTER |->
        operand_location == {8'h00, idx_reg} && pc_next == pc_reg + 16'h0001) else $error("pointer result wrong");
    ptr_byte_a: assert property (done && addr_mode == oag_pkg::MODE_POINTER_BYTE |->
        operand_location <= 16'h01fe && operand_location >= {8'h00, idx_reg} && pc_next == pc_reg + 16'h0002)
        else $error("pointer byte result wrong");
    branch_skip_a: assert property (done && addr_mode == oag_pkg::MODE_PC_OFFSET && !cond_reg |->
        pc_next == pc_reg + 16'h0002 && !operand_valid) else $error("untaken branch wrong");
    carry_copy_a: assert property (carry_we == (done && addr_mode == oag_pkg::MODE_BIT_JUMP))
        else $error("carry update strobe wrong");
    bit_strobe_a: assert property (bit_write_en == (done && addr_mode == oag_pkg::MODE_BIT_WRITE))
        else $error("bit write strobe wrong");
    cover property (take);
    cover property (carry_we && carry_bit);
    cover property (done && addr_mode == oag_pkg::MODE_PC_OFFSET && cond_reg);
endmodule

bind oag_core oag_core_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mon (.clk(clk), .reset_n(reset_n),
    .start(start), .pc_in(pc_in), .index_in(index_in), .branch_cond(branch_cond), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .busy(busy), .done(done), .addr_mode(addr_mode),
    .operand_location(operand_location), .operand_valid(operand_valid), .pc_next(pc_next), .carry_we(carry_we),
    .carry_bit(carry_bit), .bit_write_en(bit_write_en));
`default_nettype wire

// ---- tb/oag_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module oag_mem_model
(
    // Read port
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    output logic [7:0] mem_rdata
);
    // ************
    // Storage, read in the strobe cycle
    // ************
    logic [7:0] ram [0:65535];
    // Idle bus shows the inverse byte so a stray sample is caught
    assign mem_rdata = mem_rd ? ram[mem_addr] : ~ram[mem_addr];
endmodule
`default_nettype wire

// ---- tb/operand_address_generator_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module operand_address_generator_bench;
    // ************
    // Signals
    // ************
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic start = 1'b0;
    logic [15:0] pc_in = 16'h0000;
    logic [7:0] index_in = 8'h00;
    logic branch_cond = 1'b0;
    logic [15:0] mem_addr, operand_location, pc_next;
    logic [7:0] mem_rdata;
    logic mem_rd, busy, done, operand_valid, carry_we, carry_bit, bit_write_en, bit_write_value;
    logic [2:0] bit_write_num;
    oag_pkg::oag_mode_e addr_mode;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    oag_core dut (.clk(clk), .reset_n(reset_n), .start(start), .pc_in(pc_in), .index_in(index_in),
        .branch_cond(branch_cond), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .busy(busy),
        .done(done), .addr_mode(addr_mode), .operand_location(operand_location), .operand_valid(operand_valid),
        .pc_next(pc_next), .carry_we(carry_we), .carry_bit(carry_bit), .bit_write_en(bit_write_en),
        .bit_write_num(bit_write_num), .bit_write_value(bit_write_value));
    oag_mem_model mem (.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
    // ************
    // Helpers
    // ************
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            complete_run();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (done !== 1'b1 && n < 10);
        chk("done", 16'h0001, {15'h0000, done});
    endtask
    task automatic issue(input logic [15:0] pc, input logic [7:0] idx, input logic cond,
        input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
        mem.ram[pc] = b0;
        mem.ram[pc + 16'h0001] = b1;
        mem.ram[pc + 16'h0002] = b2;
        @(posedge clk);
        pc_in <= pc;
        index_in <= idx;
        branch_cond <= cond;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        wait_done();
    endtask
    task automatic res(input oag_pkg::oag_mode_e m, input logic [15:0] loc, input logic [15:0] pcn, input logic v);
        chk("mode", m, addr_mode);
        chk("pc_next", pcn, pc_next);
        chk("valid", {15'h0000, v}, {15'h0000, operand_valid});
        if (v)
            chk("location", loc, operand_location);
    endtask
    // ************
    // Scenarios
    // ************
    task automatic t_reset;
        chk("reset mode", oag_pkg::MODE_IMPLIED, addr_mode);
        chk("reset busy", 16'h0000, {15'h0000, busy});
        $display("reset done");
    endtask
    task automatic t_simple;
        issue(16'h0100, 8'h00, 1'b0, 8'h40, 8'h00, 8'h00);
        res(oag_pkg::MODE_IMPLIED, 16'h0000, 16'h0101, 1'b0);
        issue(16'h1234, 8'h00, 1'b0, 8'ha6, 8'h55, 8'h00);
        res(oag_pkg::MODE_LITERAL, 16'h1235, 16'h1236, 1'b1);
        issue(16'h2000, 8'h00, 1'b0, 8'hb7, 8'h5a, 8'h00);
        res(oag_pkg::MODE_PAGE_ZERO, 16'h005a, 16'h2002, 1'b1);
        issue(16'h2100, 8'h00, 1'b0, 8'h3a, 8'hc3, 8'h00);
        res(oag_pkg::MODE_PAGE_ZERO, 16'h00c3, 16'h2102, 1'b1);
        issue(16'h3000, 8'h00, 1'b0, 8'hc6, 8'h12, 8'h34);
        res(oag_pkg::MODE_FULL_ADDRESS, 16'h1234, 16'h3003, 1'b1);
        $display("direct done");
    endtask
    task automatic t_pointer;
        issue(16'h0200, 8'h80, 1'b0, 8'hf7, 8'h00, 8'h00);
        res(oag_pkg::MODE_POINTER, 16'h0080, 16'h0201, 1'b1);
        issue(16'h0210, 8'hff, 1'b0, 8'he6, 8'hff, 8'h00);
        res(oag_pkg::MODE_POINTER_BYTE, 16'h01fe, 16'h0212, 1'b1);
        issue(16'h0220, 8'h01, 1'b0, 8'h6c, 8'hff, 8'h00);
        res(oag_pkg::MODE_POINTER_BYTE, 16'h0100, 16'h0222, 1'b1);
        issue(16'hfffd, 8'h20, 1'b0, 8'hd6, 8'h12, 8'hf0);
        res(oag_pkg::MODE_POINTER_WORD, 16'h1310, 16'h0000, 1'b1);
        $display("pointer done");
    endtask
    task automatic t_branch;
        issue(16'h1000, 8'h00, 1'b1, 8'h20, 8'h80, 8'h00);
        res(oag_pkg::MODE_PC_OFFSET, 16'h0000, 16'h0f82, 1'b0);
        issue(16'h1000, 8'h00, 1'b0, 8'h20, 8'h80, 8'h00);
        res(oag_pkg::MODE_PC_OFFSET, 16'h0000, 16'h1002, 1'b0);
        issue(16'h1000, 8'h00, 1'b1, 8'h20, 8'h7f, 8'h00);
        res(oag_pkg::MODE_PC_OFFSET, 16'h0000, 16'h1081, 1'b0);
        $display("branch done");
    endtask
    task automatic t_bit_write;
        issue(16'h0300, 8'h00, 1'b0, 8'h10, 8'h44, 8'h00);
        res(oag_pkg::MODE_BIT_WRITE, 16'h0044, 16'h0302, 1'b1);
        chk("write one", 16'h0011, {11'h000, bit_write_en, bit_write_num, bit_write_value});
        issue(16'h0310, 8'h00, 1'b0, 8'h1f, 8'hff, 8'h00);
        chk("write zero", 16'h001e, {11'h000, bit_write_en, bit_write_num, bit_write_value});
        $display("bit write done");
    endtask
    task automatic t_bit_jump;
        mem.ram[16'h0030] = 8'h80;
        mem.ram[16'h0031] = 8'h02;
        issue(16'h4000, 8'h00, 1'b0, 8'h0e, 8'h30, 8'hfe);
        res(oag_pkg::MODE_BIT_JUMP, 16'h0030, 16'h4001, 1'b1);
        chk("carry taken", 16'h0003, {14'h0000, carry_we, carry_bit});
        issue(16'h4000, 8'h00, 1'b0, 8'h0f, 8'h30, 8'hfe);
        chk("pc untaken", 16'h4003, pc_next);
        chk("carry untaken", 16'h0003, {14'h0000, carry_we, carry_bit});
        issue(16'h4000, 8'h00, 1'b0, 8'h05, 8'h31, 8'h7f);
        chk("pc clear jump", 16'h4082, pc_next);
        chk("carry clear", 16'h0002, {14'h0000, carry_we, carry_bit});
        $display("bit jump done");
    endtask
    task automatic t_refused;
        mem.ram[16'h5000] = 8'hc6;
        mem.ram[16'h5001] = 8'hab;
        mem.ram[16'h5002] = 8'hcd;
        @(posedge clk);
        pc_in <= 16'h5000;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        pc_in <= 16'h6000;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        wait_done();
        res(oag_pkg::MODE_FULL_ADDRESS, 16'habcd, 16'h5003, 1'b1);
        $display("refusal done");
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        t_reset();
        t_simple();
        t_pointer();
        t_branch();
        t_bit_write();
        t_bit_jump();
        t_refused();
        complete_run();
    end
endmodule
`default_nettype wire
